// ### logic/dif_map.svh
// register offsets, field positions and reset values for the interrupt flag block
`ifndef DIF_MAP_SVH
`define DIF_MAP_SVH
`define DIF_OFF_CTRL         8'h08
`define DIF_OFF_MASK         8'h0C
`define DIF_OFF_FLAGS        8'h04
`define DIF_OFF_STATUS       8'h14
`define DIF_BIT_RING         7
`define DIF_BIT_RXOVL        6
`define DIF_BIT_FRAME        5
`define DIF_BIT_BILLING      4
`define DIF_BIT_DROPOUT      3
`define DIF_BIT_LOOPOVL      2
`define DIF_BIT_TIPGND       1
`define DIF_BIT_POLARITY     0
`define DIF_BIT_RING_FLAG    7
`define DIF_CTRL_IRQ_EN      7
`define DIF_CTRL_IRQ_POL     6
`define DIF_CTRL_RING_MODE   2
`define DIF_LVS_POL_BIT      7
`define DIF_CTRL_RST         8'h00
`define DIF_MASK_RST         8'h00
`define DIF_FLAGS_RST        8'h00
`define DIF_LCS_MAX          5'h1F
`endif

// ### logic/dif_pkg.sv
// types shared by the interrupt flag block
package dif_pkg;
	typedef logic [7:0] dif_byte_t;

	// raw event inputs from the line detectors
	typedef struct packed {
		logic       ring_active;
		logic       rx_overload_event;
		logic       frame_locked;
		logic       supply_disrupt_event;
		logic       supply_dropout_event;
		logic [4:0] loop_current_level;
		logic       tip_ground_status;
		logic [7:0] line_voltage_level;
	} dif_events_s;

	// register bus state
	typedef enum logic [0:0] {
		DIF_BUS_IDLE,
		DIF_BUS_ACK
	} dif_bus_e;
endpackage

// ### logic/dif_irq_flags.sv
// interrupt source flags with mask, global enable and wishbone register slave
//
// Function
// RULE1: ring detection sets flag bit 7.
// RULE2: a flag stays set until the host writes zero to that bit.
// RULE3: ring mode chooses flag at burst start only or at start and end.
// RULE4: host should clear ring and dropout flags after line-side powerup.
// RULE5: receive overload sets bit 6, and clearing it clears the overload status.
// RULE6: bit 5 sets whenever the isolation link lacks frame lock.
// RULE7: bit 4 sets when the line-side supply is disrupted.
// RULE8: bit 3 sets when the line-side supply drops out.
// RULE9: bit 2 sets when the loop current level reads all ones.
// RULE10: host should check overcurrent status after a loop overload flag.
// RULE11: bit 1 sets when tip ground current flows, inverse of tip ground status.
// RULE12: bit 0 sets on any toggle of line voltage bit 7 when supported.
// RULE13: irq asserts only while a flag is set with its mask and global enable.
// RULE14: polarity select zero gives active low irq, one gives active high.
// RULE15: writing one to a flag bit leaves it unchanged.
`include "dif_map.svh"

module dif_irq_flags #(
	parameter bit POLARITY_SUPPORTED = 1'b1
) (
	input  wire logic               clk_sys,
	input  wire logic               nrst,
	input  wire logic               wb_cyc_i,
	input  wire logic               wb_stb_i,
	input  wire logic               wb_we_i,
	input  wire logic [7:0]         wb_adr_i,
	input  wire logic [31:0]        wb_dat_i,
	input  wire logic [3:0]         wb_sel_i,
	output logic      [31:0]        wb_dat_o,
	output logic                    wb_ack_o,
	output logic                    wb_err_o,
	input  wire dif_pkg::dif_events_s events,
	output logic                    rx_overload_status,
	output logic                    shared_irq_output
);
	// reset value of the flag byte
	localparam dif_pkg::dif_byte_t FLAGS_RST = `DIF_FLAGS_RST;

	// reset synchroniser
	logic               rst_meta;
	logic               rst_n;

	// bus slave state
	dif_pkg::dif_bus_e  bus_state;
	dif_pkg::dif_bus_e  next_bus_state;
	logic               req;
	logic               take;
	logic               wr_take;
	logic               rd_take;
	logic               hit_ctrl;
	logic               hit_mask;
	logic               hit_flags;
	logic               hit_status;
	logic               mapped;
	logic               next_ack;
	logic               next_err;

	// read path
	logic [31:0]        next_rdat;

	// software visible registers
	dif_pkg::dif_byte_t ctrl;
	dif_pkg::dif_byte_t mask;
	dif_pkg::dif_byte_t flags;
	dif_pkg::dif_byte_t set_vec;
	dif_pkg::dif_byte_t clr_vec;
	dif_pkg::dif_byte_t next_flags;
	dif_pkg::dif_byte_t pending;
	logic               flags_wr;
	logic               global_irq_enable;
	logic               irq_polarity_select;
	logic               ring_irq_edge_mode;

	// previous input values and a start-up valid bit for edge detection
	logic               ring_prev;
	logic               lock_prev_valid;
	logic               lvs_prev;
	logic               tgd_prev;
	logic               dropout_prev;

	// per-source set requests
	logic               ring_start;
	logic               ring_end;
	logic               ring_set;
	logic               rxovl_set;
	logic               frame_set;
	logic               billing_set;
	logic               dropout_set;
	logic               loopovl_set;
	logic               tipgnd_set;
	logic               polarity_set;
	logic               lvs_now;

	// irq path
	logic               irq_active;
	logic               next_irq;

	// reset release through two flops
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// address decode
	always_comb begin
		hit_ctrl   = 1'b0;
		hit_mask   = 1'b0;
		hit_flags  = 1'b0;
		hit_status = 1'b0;
		case (wb_adr_i)
			`DIF_OFF_CTRL:   hit_ctrl   = 1'b1;
			`DIF_OFF_MASK:   hit_mask   = 1'b1;
			`DIF_OFF_FLAGS:  hit_flags  = 1'b1;
			`DIF_OFF_STATUS: hit_status = 1'b1;
			default:         hit_ctrl   = 1'b0;
		endcase
	end

	// request and any mapped hit
	assign req    = wb_cyc_i & wb_stb_i;
	assign mapped = hit_ctrl | hit_mask | hit_flags | hit_status;

	// a request is taken only while the slave is idle
	assign take    = req & (bus_state == dif_pkg::DIF_BUS_IDLE);
	assign wr_take = take & wb_we_i & wb_sel_i[0]; // lane 0 carries the byte
	assign rd_take = take & ~wb_we_i;

	// bus state: idle, then one answer cycle
	always_comb begin
		next_bus_state = bus_state;
		case (bus_state)
			dif_pkg::DIF_BUS_IDLE: begin
				if (req)
					next_bus_state = dif_pkg::DIF_BUS_ACK;
			end
			dif_pkg::DIF_BUS_ACK: begin
				next_bus_state = dif_pkg::DIF_BUS_IDLE;
			end
			default: begin
				next_bus_state = dif_pkg::DIF_BUS_IDLE;
			end
		endcase
	end

	// bus state register
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			bus_state <= dif_pkg::DIF_BUS_IDLE;
		else
			bus_state <= next_bus_state;
	end

	// answer kinds for a taken request
	assign next_ack = take & mapped;
	assign next_err = take & ~mapped;

	// ack for a mapped address, one cycle
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= next_ack;
	end

	// err for an unmapped address, one cycle
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			wb_err_o <= 1'b0;
		else
			wb_err_o <= next_err;
	end

	// read word for the addressed register
	always_comb begin
		next_rdat = 32'h0000_0000;
		if (hit_ctrl)
			next_rdat[7:0] = ctrl;
		else if (hit_mask)
			next_rdat[7:0] = mask;
		else if (hit_flags)
			next_rdat[7:0] = flags;
		else if (hit_status)
			next_rdat[0] = rx_overload_status;
	end

	// read data registered with the ack, held until the next read
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			wb_dat_o <= 32'h0000_0000;
		else if (rd_take)
			wb_dat_o <= next_rdat;
	end

	// control: global enable, irq polarity, ring mode
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			ctrl <= `DIF_CTRL_RST;
		else if (wr_take & hit_ctrl)
			ctrl <= wb_dat_i[7:0];
	end

	// named views of the control bits
	assign global_irq_enable   = ctrl[`DIF_CTRL_IRQ_EN];
	assign irq_polarity_select = ctrl[`DIF_CTRL_IRQ_POL];
	assign ring_irq_edge_mode  = ctrl[`DIF_CTRL_RING_MODE];

	// per-source mask, same bit layout as the flags
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			mask <= `DIF_MASK_RST;
		else if (wr_take & hit_mask)
			mask <= wb_dat_i[7:0];
	end

	// ring level one cycle back
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			ring_prev <= 1'b0;
		else
			ring_prev <= events.ring_active;
	end

	// line voltage sign bit one cycle back
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			lvs_prev <= 1'b0;
		else
			lvs_prev <= lvs_now;
	end

	// tip ground status one cycle back, idle level high avoids a false edge
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			tgd_prev <= 1'b1;
		else
			tgd_prev <= events.tip_ground_status;
	end

	// dropout event one cycle back
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			dropout_prev <= 1'b0;
		else
			dropout_prev <= events.supply_dropout_event;
	end

	// polarity detection waits one cycle after reset
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			lock_prev_valid <= 1'b0;
		else
			lock_prev_valid <= 1'b1;
	end

	// ring burst start and end
	assign ring_start = events.ring_active & ~ring_prev;
	assign ring_end   = ~events.ring_active & ring_prev;

	// ring flag: start only, or start and end by mode
	assign ring_set = ring_start | (ring_irq_edge_mode & ring_end); // RULE1 RULE3

	// receive overload: every cycle the level is high
	assign rxovl_set = events.rx_overload_event; // RULE5

	// frame lock loss: every cycle the link is unlocked
	assign frame_set = ~events.frame_locked; // RULE6

	// supply disruption: every cycle it is reported
	assign billing_set = events.supply_disrupt_event; // RULE7

	// supply dropout: once on the rising edge of the event
	assign dropout_set = events.supply_dropout_event & ~dropout_prev; // RULE8

	// loop current at full scale
	assign loopovl_set = (events.loop_current_level == `DIF_LCS_MAX); // RULE9

	// tip ground: falling status edge, the flag has the inverse sense
	assign tipgnd_set = ~events.tip_ground_status & tgd_prev; // RULE11

	// line voltage sign bit toggle in either direction
	assign lvs_now      = events.line_voltage_level[`DIF_LVS_POL_BIT];
	assign polarity_set = POLARITY_SUPPORTED & lock_prev_valid & (lvs_now ^ lvs_prev); // RULE12

	// gather the set requests in flag order
	always_comb begin
		set_vec = 8'h00;
		set_vec[`DIF_BIT_RING_FLAG] = ring_set;
		set_vec[`DIF_BIT_RXOVL]     = rxovl_set;
		set_vec[`DIF_BIT_FRAME]     = frame_set;
		set_vec[`DIF_BIT_BILLING]   = billing_set;
		set_vec[`DIF_BIT_DROPOUT]   = dropout_set;
		set_vec[`DIF_BIT_LOOPOVL]   = loopovl_set;
		set_vec[`DIF_BIT_TIPGND]    = tipgnd_set;
		set_vec[`DIF_BIT_POLARITY]  = polarity_set;
	end

	// write strobe for the flag register
	assign flags_wr = wr_take & hit_flags;

	// clear on zero write, one leaves the flag alone
	assign clr_vec = flags_wr ? ~wb_dat_i[7:0] : 8'h00; // RULE2 RULE15

	// one sticky flop per source bit
	for (genvar gi = 0; gi < 8; gi++) begin : g_flag
		// set wins over a simultaneous clear
		assign next_flags[gi] = set_vec[gi] | (flags[gi] & ~clr_vec[gi]); // RULE2
		// flag flop
		always_ff @(posedge clk_sys or negedge rst_n) begin
			if (!rst_n)
				flags[gi] <= FLAGS_RST[gi];
			else
				flags[gi] <= next_flags[gi];
		end
	end

	// overload status follows the flag, a flag clear also clears it
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			rx_overload_status <= 1'b0;
		else
			rx_overload_status <= next_flags[`DIF_BIT_RXOVL]; // RULE5
	end

	// flags that are both set and unmasked
	assign pending = flags & mask;

	// any pending flag with the global enable raises the irq
	assign irq_active = global_irq_enable & (|pending); // RULE13

	// pin level: polarity zero drives low when active
	assign next_irq = irq_active ~^ irq_polarity_select; // RULE14

	// pin registered, idles high after reset for the low-active default
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			shared_irq_output <= 1'b1;
		else
			shared_irq_output <= next_irq;
	end
endmodule

// ### verif/dif_irq_flags_assertions.sv
// bus and overload flag checks for the interrupt flag block
module dif_chk (
	input wire logic                 clk_sys,
	input wire logic                 nrst,
	input wire logic                 wb_cyc_i,
	input wire logic                 wb_stb_i,
	input wire logic                 wb_we_i,
	input wire logic                 wb_ack_o,
	input wire logic                 wb_err_o,
	input wire dif_pkg::dif_events_s events,
	input wire logic                 rx_overload_status
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	// request taken while the slave is idle
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	endsequence
	property p_answer; s_req |=> wb_ack_o || wb_err_o; endproperty
	a_answer: assert property (p_answer) else $error("no answer");
	property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("long ack");
	property p_err_pulse; wb_err_o |=> !wb_err_o; endproperty
	a_err_pulse: assert property (p_err_pulse) else $error("long err");
	property p_excl; !(wb_ack_o && wb_err_o); endproperty
	a_excl: assert property (p_excl) else $error("ack with err");
	property p_quiet; !wb_cyc_i |=> !wb_ack_o && !wb_err_o; endproperty
	a_quiet: assert property (p_quiet) else $error("answer without request");
	property p_ack_cause; $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i); endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without cause");
	property p_ovl_set; events.rx_overload_event |-> ##[1:2] rx_overload_status; endproperty
	a_ovl_set: assert property (p_ovl_set) else $error("overload not shown");
	// only a host write may drop the sticky overload
	property p_ovl_hold;
		$fell(rx_overload_status) |-> wb_cyc_i && wb_we_i || $past(wb_cyc_i && wb_we_i);
	endproperty
	a_ovl_hold: assert property (p_ovl_hold) else $error("overload dropped");
endmodule

bind dif_irq_flags dif_chk u_chk (.clk_sys, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_ack_o, .wb_err_o, .events, .rx_overload_status);

// ### verif/dif_host_model.sv
// host side view of the shared interrupt pin
module dif_host_model (
	input  wire logic shared_irq_output,
	input  wire logic irq_polarity_select,
	output logic      irq_pending
);
	// pending when the pin sits at the selected active level
	assign irq_pending = (shared_irq_output === irq_polarity_select);
endmodule

// ### verif/dif_irq_flags_tb.sv
// self-checking bench for the interrupt flag block
`include "dif_map.svh"
module dif_irq_flags_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] FL = `DIF_OFF_FLAGS;
	localparam logic [18:0] IDLE = 19'h10100;
	localparam logic [18:0] TGL [8] = '{19'h40000, 19'h20000, 19'h10000, 19'h08000,
		19'h04000, 19'h03E00, 19'h00100, 19'h00080};
	localparam logic [16:0] IRQ_T [4] = '{17'h00400, 17'h0FBC0, 17'h10480, 17'h104C0};
	logic clk_sys, nrst, cyc, stb, we, ack, err, ovl, irq, pol, pend, be;
	logic [7:0] adr, q, b;
	logic [31:0] wdat, rdat;
	logic [3:0] sel;
	dif_pkg::dif_events_s ev;
	int num_errors, check_count;
	dif_irq_flags u_dut (.clk_sys, .nrst, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
		.wb_err_o(err), .events(ev), .rx_overload_status(ovl), .shared_irq_output(irq));
	dif_host_model u_host (.shared_irq_output(irq), .irq_polarity_select(pol),
		.irq_pending(pend));
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	initial begin
		#200000;
		num_errors++;
		stop_test();
	end
	task automatic stop_test();
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask
	// one classic cycle, held until ack or err is sampled
	task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d,
		input logic [3:0] s);
		@(posedge clk_sys);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h0, d};
		sel <= s;
		do begin
			@(posedge clk_sys);
		end while (ack !== 1'b1 && err !== 1'b1);
		q = rdat[7:0];
		be = err;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(a, 1'b1, d, 4'hF);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
		bus(a, 1'b0, 8'h00, 4'hF);
		chk(n, e, q);
	endtask
	initial begin
		{cyc, stb, we, adr, wdat, sel, pol} = '0;
		ev = IDLE;
		nrst = 1'b0;
		repeat (10) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		chk("irq_rst", 8'h01, {7'h00, irq});
		wr(FL, 8'h00);
		rd(FL, 8'h00, "flags_rst");
		bus(8'h00, 1'b0, 8'h00, 4'hF);
		chk("unmapped", 8'h01, {7'h00, be});
		// each source in turn: set, sticky, ones ignored, zero clears
		for (int i = 0; i < 8; i++) begin
			b = 8'h80 >> i;
			@(posedge clk_sys);
			ev <= IDLE ^ TGL[i];
			repeat (3) @(posedge clk_sys);
			chk("ovl_set", {7'h00, i == 1}, {7'h00, ovl});
			ev <= IDLE;
			rd(FL, b, "flag_set");
			wr(FL, 8'hFF);
			rd(FL, b, "flag_ones");
			bus(FL, 1'b1, 8'h00, 4'h0);
			rd(FL, b, "flag_nosel");
			wr(FL, ~b);
			rd(FL, 8'h00, "flag_clr");
			chk("ovl_clr", 8'h00, {7'h00, ovl});
		end
		for (int k = 0; k < 2; k++) begin
			wr(`DIF_OFF_CTRL, k ? 8'h04 : 8'h00);
			ev <= IDLE ^ TGL[0];
			wr(FL, 8'h00);
			ev <= IDLE;
			repeat (3) @(posedge clk_sys);
			rd(FL, k ? 8'h80 : 8'h00, "ring_end");
			wr(FL, 8'h00);
		end
		ev <= IDLE ^ TGL[5];
		repeat (2) @(posedge clk_sys);
		ev <= IDLE;
		for (int j = 0; j < 4; j++) begin
			wr(`DIF_OFF_MASK, IRQ_T[j][15:8]);
			wr(`DIF_OFF_CTRL, IRQ_T[j][7:0]);
			pol <= IRQ_T[j][6];
			repeat (2) @(posedge clk_sys);
			chk("irq", {7'h00, IRQ_T[j][16]}, {7'h00, pend});
		end
		rd(FL, 8'h04, "loop_flag");
		rd(`DIF_OFF_STATUS, 8'h00, "status_after_loop");
		wr(FL, 8'h00);
		repeat (2) @(posedge clk_sys);
		chk("irq_clr", 8'h00, {7'h00, pend});
		stop_test();
	end
endmodule
